// file: logic/pewi_defines.svh
`ifndef PEWI_DEFINES_SVH
`define PEWI_DEFINES_SVH
// Function
// - each of eight pins watched on its own for a rising or falling edge
// - edge select bit 1 picks falling, 0 picks rising
// - after reset every pin detects falling edges
// - selected edge on a pin sets its pending flag bit
// - pending flags are sticky; only software clears them
// - edge detection always runs, configured or not
// - mode 0x0a routes configuration writes to the edge select register
// - mode 0x0b routes configuration writes to the wake enable register
// - mode 0x09 access returns pending flags and writes operand into them
// - wake enable bit 1 disables the pin interrupt, 0 enables it
// - after reset wake interrupts are disabled on all pins
// - enabled edge raises an interrupt and wakes the core; one arriving while a latency count runs only wakes, with no routine start
// - no new interrupt from a pin while its pending flag is set
// - disabled pin edge sets pending flag but does not wake
// - interrupt starts execution at program address zero
// - routine starts 5 cycles after event in turbo, 10 in compatible
// - asynchronous edges may add up to one more cycle of latency
// - mode 0x0f writes directions; 1 is input, 0 is output

// ----------------------------------------
// mode selector codes
// ----------------------------------------
`define PEWI_MODE_PEND 4'h9
`define PEWI_MODE_EDGE 4'ha
`define PEWI_MODE_WAKE 4'hb
`define PEWI_MODE_DIR 4'hf
`define PEWI_MODE_RST 4'hf

// ----------------------------------------
// reset values
// ----------------------------------------
`define PEWI_EDGE_RST 8'hff
`define PEWI_WAKE_RST 8'hff
`define PEWI_DIR_RST 8'hff
`define PEWI_PEND_RST 8'h00
`define PEWI_VECTOR 11'h000

// ----------------------------------------
// interrupt latency in core cycles
// ----------------------------------------
`define PEWI_LAT_TURBO 4'h5
`define PEWI_LAT_COMPAT 4'ha

`endif

// file: logic/pewi_pkg.sv
package pewi_pkg;
    typedef struct packed {
        logic wr;
        logic [3:0] code;
    } pewi_mode_s;

    typedef struct packed {
        logic wr;
        logic [7:0] data;
    } pewi_cfg_s;

    typedef enum logic [1:0] {
        PEWI_LAT_IDLE = 2'b01,
        PEWI_LAT_COUNT = 2'b10
    } pewi_lat_e;
endpackage : pewi_pkg

// file: logic/pewi_edge_sync.sv
`timescale 1ns/10ps
module pewi_edge_sync #(
    parameter int PINS = 8
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [PINS-1:0] pin_i,
    input wire logic [PINS-1:0] fall_sel_i,
    output logic [PINS-1:0] hit_o
);
    import pewi_pkg::*;

    // ----------------------------------------
    // per pin synchroniser and edge compare
    // ----------------------------------------
    for (genvar i = 0; i < PINS; i++) begin : g_pin
        logic s1_reg, s2_reg, s3_reg, lvl_reg, primed_reg;
        logic lvl_next, primed_next, agree;

        // a change counts only once the second and third stages agree
        always_comb begin
            agree = (s2_reg == s3_reg);
            lvl_next = agree ? s2_reg : lvl_reg;
            primed_next = primed_reg | agree;
            hit_o[i] = primed_reg & agree & (s2_reg != lvl_reg)
                & (fall_sel_i[i] ? ~s2_reg : s2_reg);
        end

        always_ff @(posedge clk_i or posedge rst_i) begin
            if (rst_i) begin
                s1_reg <= 1'b0;
                s2_reg <= 1'b0;
                s3_reg <= 1'b0;
                lvl_reg <= 1'b0;
                primed_reg <= 1'b0;
            end else begin
                s1_reg <= pin_i[i];
                s2_reg <= s1_reg;
                s3_reg <= s2_reg;
                lvl_reg <= lvl_next;
                primed_reg <= primed_next;
            end
        end
    end
endmodule : pewi_edge_sync

// file: logic/pewi_top.sv
`timescale 1ns/10ps
`include "pewi_defines.svh"
module pewi_top #(
    parameter int PINS = 8
) (
    input wire logic SYS_CLK_I,
    input wire logic RST_I,
    input wire logic [PINS-1:0] PIN_I,
    input wire logic TURBO_I,
    input wire pewi_pkg::pewi_mode_s MODE_I,
    input wire pewi_pkg::pewi_cfg_s CFG_I,
    output logic [7:0] CFG_RDATA_O,
    output logic CFG_RVALID_O,
    output logic [7:0] PIN_DIR_O,
    output logic WAKE_O,
    output logic INT_START_O,
    output logic [10:0] INT_VECTOR_O,
    output logic INT_BUSY_O
);
    import pewi_pkg::*;

    // ----------------------------------------
    // elaboration checks
    // ----------------------------------------
    // configuration data is one byte wide, so at most eight pins
    if (PINS < 1 || PINS > 8) begin : g_bad_pins
        $error("PINS must lie between 1 and 8");
    end

    // ----------------------------------------
    // edge detection
    // ----------------------------------------
    logic [PINS-1:0] hit_w;
    logic [7:0] hit8;
    logic [7:0] edge_reg, edge_next;

    pewi_edge_sync #(
        .PINS(PINS)
    ) u_sync (
        .clk_i(SYS_CLK_I),
        .rst_i(RST_I),
        .pin_i(PIN_I),
        .fall_sel_i(edge_reg[PINS-1:0]),
        .hit_o(hit_w)
    );

    assign hit8 = 8'(hit_w);

    // ----------------------------------------
    // mode selector and configuration registers
    // ----------------------------------------
    logic [3:0] mode_reg, mode_next;
    logic [7:0] wake_reg, wake_next;
    logic [7:0] dir_reg, dir_next;
    logic [7:0] pend_reg, pend_next;
    logic [7:0] rdata_reg, rdata_next;
    logic rvalid_reg, rvalid_next;
    logic exch;

    // a configuration access uses the mode in force before this cycle
    always_comb begin
        mode_next = mode_reg;
        edge_next = edge_reg;
        wake_next = wake_reg;
        dir_next = dir_reg;
        rdata_next = rdata_reg;
        rvalid_next = 1'b0;
        exch = CFG_I.wr && (mode_reg == `PEWI_MODE_PEND);
        if (MODE_I.wr) begin
            mode_next = MODE_I.code;
        end
        if (CFG_I.wr) begin
            case (mode_reg)
                `PEWI_MODE_EDGE: begin
                    edge_next = CFG_I.data;
                end
                `PEWI_MODE_WAKE: begin
                    wake_next = CFG_I.data;
                end
                `PEWI_MODE_DIR: begin
                    dir_next = CFG_I.data;
                end
                `PEWI_MODE_PEND: begin
                    rdata_next = pend_reg;
                    rvalid_next = 1'b1;
                end
                default: begin
                    rdata_next = rdata_reg;
                end
            endcase
        end
        // edge of this cycle is ORed after the write so it is never lost
        pend_next = (exch ? CFG_I.data : pend_reg) | hit8;
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            mode_reg <= `PEWI_MODE_RST;
            edge_reg <= `PEWI_EDGE_RST;
            wake_reg <= `PEWI_WAKE_RST;
            dir_reg <= `PEWI_DIR_RST;
            pend_reg <= `PEWI_PEND_RST;
            rdata_reg <= 8'h00;
            rvalid_reg <= 1'b0;
        end else begin
            mode_reg <= mode_next;
            edge_reg <= edge_next;
            wake_reg <= wake_next;
            dir_reg <= dir_next;
            pend_reg <= pend_next;
            rdata_reg <= rdata_next;
            rvalid_reg <= rvalid_next;
        end
    end

    assign CFG_RDATA_O = rdata_reg;
    assign CFG_RVALID_O = rvalid_reg;
    assign PIN_DIR_O = dir_reg;

    // ----------------------------------------
    // wake and interrupt latency
    // ----------------------------------------
    logic [7:0] raise;
    logic irq_evt;
    pewi_lat_e state_reg, state_next;
    logic [3:0] cnt_reg, cnt_next;
    logic [3:0] lat_reg, lat_next;
    logic start_reg, start_next;
    logic wake_o_reg, wake_o_next;

    // a set pending flag masks further interrupts from that pin
    assign raise = hit8 & ~wake_reg & ~pend_reg;
    assign irq_evt = |raise;

    // latency is fixed from the synchronised event; the synchroniser
    // itself accounts for the extra cycle allowed on asynchronous edges
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        lat_next = lat_reg;
        start_next = 1'b0;
        wake_o_next = irq_evt;
        case (state_reg)
            PEWI_LAT_IDLE: begin
                if (irq_evt) begin
                    state_next = PEWI_LAT_COUNT;
                    cnt_next = 4'h1;
                    lat_next = TURBO_I ? `PEWI_LAT_TURBO
                        : `PEWI_LAT_COMPAT;
                end
            end
            PEWI_LAT_COUNT: begin
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg == lat_reg - 4'h1) begin
                    start_next = 1'b1;
                    state_next = PEWI_LAT_IDLE;
                    cnt_next = 4'h0;
                end
            end
            default: begin
                state_next = PEWI_LAT_IDLE;
                cnt_next = 4'h0;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            state_reg <= PEWI_LAT_IDLE;
            cnt_reg <= 4'h0;
            lat_reg <= `PEWI_LAT_COMPAT;
            start_reg <= 1'b0;
            wake_o_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            lat_reg <= lat_next;
            start_reg <= start_next;
            wake_o_reg <= wake_o_next;
        end
    end

    assign INT_START_O = start_reg;
    assign WAKE_O = wake_o_reg;
    assign INT_BUSY_O = state_reg[1]; // one-hot count bit, taken straight from the flop

    // the vector never changes; the service routine sits at address zero
    logic [10:0] vec_reg;
    always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
        if (RST_I) begin
            vec_reg <= `PEWI_VECTOR;
        end else begin
            vec_reg <= `PEWI_VECTOR;
        end
    end
    assign INT_VECTOR_O = vec_reg;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge SYS_CLK_I);
    endclocking
    default disable iff (RST_I);

    sequence s_evt_turbo;
        irq_evt && (state_reg == PEWI_LAT_IDLE) && TURBO_I;
    endsequence

    sequence s_evt_compat;
        irq_evt && (state_reg == PEWI_LAT_IDLE) && !TURBO_I;
    endsequence

    sequence s_start_once;
        INT_START_O ##1 !INT_START_O;
    endsequence

    // the count stands for lat-1 cycles and drops as the routine starts
    sequence s_busy_turbo;
        INT_BUSY_O[*4] ##1 !INT_BUSY_O;
    endsequence

    sequence s_busy_compat;
        INT_BUSY_O[*8] ##1 INT_BUSY_O ##1 !INT_BUSY_O;
    endsequence

    // ----------------------------------------
    // interrupt latency checks
    // ----------------------------------------
    a_turbo_latency: assert property (s_evt_turbo
        |-> ##1 !INT_START_O[*4] ##1 s_start_once)
        else $error("turbo interrupt start not 5 cycles after event");

    a_compat_latency: assert property (s_evt_compat |-> ##10 INT_START_O)
        else $error("compatible interrupt start not 10 cycles after event");

    a_busy_turbo: assert property (s_evt_turbo |=> s_busy_turbo)
        else $error("turbo latency count has the wrong length");

    a_busy_compat: assert property (s_evt_compat |=> s_busy_compat)
        else $error("compatible latency count has the wrong length");

    a_start_ends: assert property (INT_START_O |-> !INT_BUSY_O && $past(INT_BUSY_O))
        else $error("routine start without a finished latency count");

    a_vector_zero: assert property (INT_START_O |-> INT_VECTOR_O == `PEWI_VECTOR)
        else $error("routine start with a nonzero vector");

    // ----------------------------------------
    // pending flag checks
    // ----------------------------------------
    a_pend_sticky: assert property (!exch
        |=> (pend_reg & $past(pend_reg)) == $past(pend_reg))
        else $error("pending flag cleared without software write");

    a_edge_sets: assert property (hit8 != 8'h00
        |=> (pend_reg & $past(hit8)) == $past(hit8))
        else $error("detected edge did not set pending flag");

    a_exch_read: assert property (exch |=> CFG_RVALID_O && CFG_RDATA_O == $past(pend_reg))
        else $error("exchange did not return old pending flags");

    a_exch_write: assert property (exch
        |=> pend_reg == ($past(CFG_I.data) | $past(hit8)))
        else $error("exchange did not load the operand into pending flags");

    a_rvalid_pulse: assert property (CFG_RVALID_O |-> $past(exch))
        else $error("read valid without an exchange");

    // ----------------------------------------
    // register write checks
    // ----------------------------------------
    a_mode_write: assert property (MODE_I.wr |=> mode_reg == $past(MODE_I.code))
        else $error("mode selector write lost");

    a_edge_write: assert property (CFG_I.wr && mode_reg == `PEWI_MODE_EDGE
        |=> edge_reg == $past(CFG_I.data))
        else $error("edge select write lost");

    a_wake_write: assert property (CFG_I.wr && mode_reg == `PEWI_MODE_WAKE
        |=> wake_reg == $past(CFG_I.data))
        else $error("wake enable write lost");

    a_dir_write: assert property (CFG_I.wr && mode_reg == `PEWI_MODE_DIR
        |=> PIN_DIR_O == $past(CFG_I.data))
        else $error("direction write lost");

    // other codes belong to configuration kept outside this block
    a_refused_cfg: assert property (CFG_I.wr
        && !(mode_reg inside {`PEWI_MODE_PEND, `PEWI_MODE_EDGE, `PEWI_MODE_WAKE, `PEWI_MODE_DIR})
        |=> $stable(edge_reg) && $stable(wake_reg) && $stable(dir_reg))
        else $error("write under an unknown mode changed a register");

    // ----------------------------------------
    // wake checks
    // ----------------------------------------
    a_masked_nowake: assert property ((hit8 & ~wake_reg & ~pend_reg) == 8'h00
        |=> !WAKE_O)
        else $error("wake raised by masked or pending pin");

    a_enabled_wakes: assert property (irq_evt
        |=> WAKE_O ##1 (WAKE_O == $past(irq_evt)))
        else $error("enabled edge did not wake the core");

    a_wake_source: assert property (WAKE_O
        |-> ($past(hit8) & ~$past(wake_reg)) != 8'h00)
        else $error("wake raised with no edge on an enabled pin");
endmodule : pewi_top

// file: test/pewi_pin_model.sv
`timescale 1ns/10ps
// ----------------------------------------
// external pin drivers
// ----------------------------------------
module pewi_pin_model (
    input wire logic clk_i,
    input wire logic [7:0] level_i,
    output logic [7:0] pin_o
);
    // idle high; the rise from the synchroniser's reset zeros is a rising edge, unseen under the falling default
    initial pin_o = 8'hff;
    // each pin moves on its own, changed just after a clock edge
    always @(posedge clk_i) begin
        pin_o <= level_i;
    end
endmodule : pewi_pin_model

// file: test/port_edge_wakeup_interrupt_tb.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin num_errors++; \
    $display("[FAIL] %0t mismatch got %h exp %h", $time, a, b); end end
module port_edge_wakeup_interrupt_tb;
    import pewi_pkg::*;
    // ----------------------------------------
    // signals and instances
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic turbo = 1'b0;
    logic [7:0] level = 8'hff;
    logic [7:0] pins;
    pewi_mode_s mode = '0;
    pewi_cfg_s cfg = '0;
    logic [7:0] rdata, dir;
    logic rvalid, wake, start, busy;
    logic [10:0] vec;
    int num_errors = 0;
    int checks_done = 0;
    int cycles = 0;
    initial forever #5 clk = ~clk;
    pewi_pin_model pin_u (.clk_i(clk), .level_i(level), .pin_o(pins));
    pewi_top dut_u (.SYS_CLK_I(clk), .RST_I(rst), .PIN_I(pins), .TURBO_I(turbo),
        .MODE_I(mode), .CFG_I(cfg), .CFG_RDATA_O(rdata), .CFG_RVALID_O(rvalid),
        .PIN_DIR_O(dir), .WAKE_O(wake), .INT_START_O(start), .INT_VECTOR_O(vec),
        .INT_BUSY_O(busy));
    // ----------------------------------------
    // tasks and expectations
    // ----------------------------------------
    task automatic stop_test;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            stop_test();
        end
    end
    function automatic logic [7:0] hits(logic [7:0] o, logic [7:0] n, logic [7:0] fall);
        return (fall & o & ~n) | (~fall & ~o & n);
    endfunction : hits
    task automatic mode_wr(input logic [3:0] code);
        @(posedge clk) mode <= '{wr: 1'b1, code: code};
        @(posedge clk) mode.wr <= 1'b0;
    endtask : mode_wr
    task automatic cfg_wr(input logic [3:0] code, input logic [7:0] d);
        mode_wr(code);
        @(posedge clk) cfg <= '{wr: 1'b1, data: d};
        @(posedge clk) cfg.wr <= 1'b0;
    endtask : cfg_wr
    task automatic exchange(input logic [7:0] d, output logic [7:0] old);
        cfg_wr(4'h9, d);
        #1;
        `CHK(rvalid, 1'b1)
        old = rdata;
    endtask : exchange
    // drive new levels, then watch wake and routine start
    task automatic pin_set(input logic [7:0] v, output logic woke, output int gap);
        int cnt;
        woke = 1'b0;
        gap = -1;
        cnt = 0;
        @(posedge clk) level <= v;
        repeat (18) begin
            @(posedge clk) #1;
            if (wake === 1'b1) begin
                if (!woke) begin
                    `CHK(busy, 1'b1)
                end
                woke = 1'b1;
                cnt = 0;
            end else if (woke) begin
                cnt++;
            end
            if (start === 1'b1 && gap < 0) begin
                gap = cnt;
                `CHK(vec, 11'h000)
                `CHK(busy, 1'b0)
            end
        end
    endtask : pin_set
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        logic [7:0] old, old2, lv, nl, e, wm, d, h, pend, bitm;
        logic woke;
        int gap, p;
        void'($urandom(32'h83a5ca4a));
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        `CHK(dir, 8'hff)
        `CHK(wake, 1'b0)
        exchange(8'h00, old);
        `CHK(old, 8'h00)
        // defaults: falling edges, wake disabled, no configuration at all
        lv = 8'h0f ^ 8'($urandom());
        pin_set(lv, woke, gap);
        `CHK(woke, 1'b0)
        exchange(8'h00, old);
        `CHK(old, ~lv)
        // configure in the software order, then clear pending
        e = 8'($urandom());
        wm = 8'($urandom()) & 8'h7e;
        d = 8'($urandom());
        cfg_wr(4'ha, e);
        cfg_wr(4'hb, wm);
        cfg_wr(4'hf, d);
        #1;
        `CHK(dir, d)
        cfg_wr(4'he, ~d);
        #1;
        `CHK(dir, d)
        exchange(8'h00, old);
        pend = 8'h00;
        for (int i = 0; i < 8; i++) begin
            p = (i < 2) ? i * 7 : $urandom_range(7);
            turbo <= 1'($urandom());
            bitm = 8'h01 << p;
            // two round trips: the second selected edge meets a set flag
            repeat (4) begin
                nl = lv ^ bitm;
                h = hits(lv, nl, e);
                pin_set(nl, woke, gap);
                `CHK(woke, |(h & ~pend & ~wm))
                if (woke) begin
                    `CHK(gap, turbo ? 4 : 9)
                end
                pend = pend | h;
                lv = nl;
            end
            exchange(8'h00, old);
            `CHK(old, pend)
            d = (8'($urandom()) | old) & ~bitm;
            exchange(d, old2);
            `CHK(old2, 8'h00)
            exchange(8'h00, old2);
            `CHK(old2, d)
            pend = 8'h00;
        end
        // reset in mid-run must restore falling edges and disabled wakes
        @(posedge clk) rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        `CHK(dir, 8'hff)
        `CHK(busy, 1'b0)
        pin_set(~lv, woke, gap);
        `CHK(woke, 1'b0)
        exchange(8'h00, old);
        `CHK(old, lv)
        stop_test();
    end
endmodule : port_edge_wakeup_interrupt_tb
